// File: fic_pkg.sv
package fic_pkg;
  localparam int          REG_W       = 16;
  localparam int          ADDR_W      = 7;
  localparam int          FRAME_BITS  = 24;
  localparam int          FRAME_MAX   = 31;
  localparam logic [6:0]  FIC_ADDR    = 7'h2F;
  localparam logic [15:0] FIC_RESET   = 16'h0000;
  localparam int          BIT_CRC     = 15;
  localparam int          BIT_VREF    = 14;
  localparam int          BIT_TERR    = 13;
  localparam int          BIT_TWARN   = 12;
  localparam int          BIT_OUT_HI  = 9;
  localparam int          BIT_OUT_LO  = 8;
  localparam int          BIT_FLAT_HI = 7;
  localparam int          BIT_FLAT_LO = 6;
  localparam int          BIT_CORE_HI = 5;
  localparam int          BIT_CORE_LO = 4;
  localparam int          BIT_ANA_HI  = 3;
  localparam int          BIT_ANA_LO  = 2;
  localparam int          BIT_REF_HI  = 1;
  localparam int          BIT_REF_LO  = 0;
  localparam int          CRC_POLY    = 8'h07;

  typedef struct packed {
    logic       refFail;
    logic       overtempError;
    logic       overtempWarning;
    logic [4:0] monitorHigh;
    logic [4:0] monitorLow;
  } fic_fault_t;
endpackage

// File: fic_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fic_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         mclk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// File: fic_top.sv
// Behaviour
// - check byte inverted on serial output while bit 15 set
// - bit 14 reports a reference failure as if detected
// - bit 13 raises over-temperature error regardless of real temperature
// - bit 12 raises thermal warning regardless of real temperature
// - bits 9/8 force output-monitor high/low limit failure
// - bits 7/6 force flat-node monitor high/low failure
// - bits 5/4 force core-supply monitor high/low failure
// - bits 3/2 force analog-supply monitor high/low failure
// - bits 1/0 force reference monitor high/low failure
// - register at 2Fh, resets 0000h, all bits read-write
// - transactions accepted only while chip select low
// - serial output can go high-impedance for a shared line
// - alarm output is open-drain for a wired shared line
`timescale 1ns/1ps
`default_nettype none
module fic_top
  import fic_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // serial pins
  input  wire logic                sclk,
  input  wire logic                csN,
  input  wire logic                sdi,
  output logic                     sdoOut,
  output logic                     sdoOeN,
  // alarm pin
  output logic                     alarmOut,
  output logic                     alarmOeN,
  // genuine detector inputs
  input  wire fic_pkg::fic_fault_t realFault,
  // fault view and control
  output fic_pkg::fic_fault_t      faultFlags,
  output logic                     failSafe,
  output logic [15:0]              injectState
);
  import fic_pkg::*;

  logic [2:0]  pinSync;
  logic        sclkPrev_reg;
  logic        frameActive;
  logic        riseEdge;
  logic        fallEdge;
  logic [4:0]  bitCnt_reg;
  logic [23:0] shiftIn_reg;
  logic [23:0] shiftOut_reg;
  logic [7:0]  crc_reg;
  logic [15:0] inject_reg;
  logic        sdoData_reg;
  fic_fault_t  forced;
  fic_fault_t  merged;
  fic_fault_t  flags_reg;

  fic_sync #(.W(3)) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn ({sclk, csN, sdi}),
    .syncOut (pinSync)
  );

  assign frameActive = !pinSync[1];
  assign riseEdge    = frameActive && pinSync[2] && !sclkPrev_reg;
  assign fallEdge    = frameActive && !pinSync[2] && sclkPrev_reg;

  function automatic logic [7:0] crcStep(input logic [7:0] c,
                                         input logic       b);
    logic fb;
    fb = c[7] ^ b;
    crcStep = {c[6:0], 1'b0} ^ (fb ? CRC_POLY[7:0] : 8'h00);
  endfunction

  always_ff @(posedge mclk) begin
    if (rst) sclkPrev_reg <= 1'b0;
    else     sclkPrev_reg <= pinSync[2];
  end

  // frame: R/W bit, 7-bit address, 16-bit data
  always_ff @(posedge mclk) begin
    if (rst || !frameActive) begin
      bitCnt_reg  <= 5'h00;
      shiftIn_reg <= 24'h000000;
    end else if (riseEdge && bitCnt_reg != 5'(FRAME_MAX)) begin
      bitCnt_reg  <= bitCnt_reg + 5'h01;
      shiftIn_reg <= {shiftIn_reg[22:0], pinSync[0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      inject_reg <= FIC_RESET;
    end else if (frameActive && bitCnt_reg == 5'(FRAME_BITS - 1) && riseEdge
                 && !shiftIn_reg[22] && shiftIn_reg[21:15] == FIC_ADDR) begin
      inject_reg <= {shiftIn_reg[14:0], pinSync[0]};
    end
  end

  // read: after 8 header bits, 16 data bits then check byte
  always_ff @(posedge mclk) begin
    if (rst || !frameActive) begin
      shiftOut_reg <= 24'h000000;
      crc_reg      <= 8'h00;
      sdoData_reg  <= 1'b0;
    end else if (riseEdge && bitCnt_reg == 5'h07) begin
      shiftOut_reg <= {({shiftIn_reg[6:0], pinSync[0]} == FIC_ADDR + 8'h80)
                       ? inject_reg : 16'h0000, 8'h00};
      crc_reg      <= 8'h00;
    end else if (fallEdge && bitCnt_reg >= 5'h08) begin
      // check byte follows the last data bit on further clocks
      sdoData_reg  <= shiftOut_reg[23];
      crc_reg      <= crcStep(crc_reg, shiftOut_reg[23]);
      shiftOut_reg <= {shiftOut_reg[22:0], 1'b0};
      if (bitCnt_reg == 5'h17)
        shiftOut_reg[23:16] <= inject_reg[BIT_CRC]
          ? ~crcStep(crc_reg, shiftOut_reg[23])
          : crcStep(crc_reg, shiftOut_reg[23]);
    end
  end

  // check byte trails the data after the frame's 24 bits
  assign sdoOut = sdoData_reg;
  assign sdoOeN = !frameActive;

  always_comb begin
    forced.refFail         = inject_reg[BIT_VREF];
    forced.overtempError   = inject_reg[BIT_TERR];
    forced.overtempWarning = inject_reg[BIT_TWARN];
    forced.monitorHigh     = {inject_reg[BIT_OUT_HI],
                              inject_reg[BIT_FLAT_HI],
                              inject_reg[BIT_CORE_HI],
                              inject_reg[BIT_ANA_HI],
                              inject_reg[BIT_REF_HI]};
    forced.monitorLow      = {inject_reg[BIT_OUT_LO],
                              inject_reg[BIT_FLAT_LO],
                              inject_reg[BIT_CORE_LO],
                              inject_reg[BIT_ANA_LO],
                              inject_reg[BIT_REF_LO]};
    merged = realFault | forced;
  end

  always_ff @(posedge mclk) begin
    if (rst) flags_reg <= '0;
    else     flags_reg <= merged;
  end

  assign faultFlags  = flags_reg;
  assign failSafe    = |flags_reg;
  assign alarmOut    = 1'b0;
  assign alarmOeN    = !(|flags_reg);
  assign injectState = inject_reg;

  reset_value_a: assert property (@(posedge mclk)
    $fell(rst) |-> inject_reg == 16'h0000)
    else $error("inject register not cleared by reset");
  sdo_release_a: assert property (@(posedge mclk) disable iff (rst)
    pinSync[1] |-> sdoOeN)
    else $error("serial output driven while deselected");
  flag_follow_a: assert property (@(posedge mclk) disable iff (rst)
    inject_reg[BIT_TERR] |=> faultFlags.overtempError)
    else $error("forced over-temperature not reported");
  warn_follow_a: assert property (@(posedge mclk) disable iff (rst)
    inject_reg[BIT_TWARN] |=> faultFlags.overtempWarning)
    else $error("forced warning not reported");
  ref_follow_a: assert property (@(posedge mclk) disable iff (rst)
    inject_reg[BIT_VREF] |=> faultFlags.refFail)
    else $error("forced reference failure not reported");
  mon_follow_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> faultFlags.monitorHigh[4] ==
      $past(inject_reg[BIT_OUT_HI] | realFault.monitorHigh[4]))
    else $error("output monitor flag wrong");
  alarm_drive_a: assert property (@(posedge mclk) disable iff (rst)
    !alarmOeN |-> failSafe && alarmOut == 1'b0)
    else $error("alarm driven without a fault");
  clear_ends_a: assert property (@(posedge mclk) disable iff (rst)
    (inject_reg == 16'h0000 && realFault == '0) [*2] |-> !failSafe)
    else $error("fault persists after injection cleared");
  no_write_a: assert property (@(posedge mclk) disable iff (rst)
    pinSync[1] |=> $stable(inject_reg))
    else $error("register written while deselected");
  write_seen_c: cover property (@(posedge mclk) $changed(inject_reg));
  crc_inject_c: cover property (@(posedge mclk)
    inject_reg[BIT_CRC] && fallEdge && bitCnt_reg == 5'h17);
  alarm_on_c: cover property (@(posedge mclk) $fell(alarmOeN));
endmodule
`default_nettype wire

// File: fic_host.sv
`timescale 1ns/1ps
`default_nettype none
module fic_host (
  // timing reference
  input  wire logic mclk,
  // serial lines
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    sdi  = 1'b1;
  end
  // own select held low all frame, msb first
  task automatic xfer(input logic [23:0] f, input int n,
                      output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge mclk) #1;
    csN = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 24) ? f[23-i] : 1'b0;
      #160 sclk = 1'b1;
      if (i >= 8) rd = {rd[14:0], sdo};
      #160 sclk = 1'b0;
    end
    #160;
  endtask
  // released data line flips away from its last bit
  task automatic releaseBus();
    csN = 1'b1;
    sdi = ~sdi;
    #160;
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fic_pkg::*;
  logic       mclk, rst, sclk, csN, sdi, sdoOut, sdoOeN, sdoLine;
  logic       alarmOut, alarmOeN, failSafe;
  logic [15:0] injectState, rd, w;
  fic_fault_t realFault, faultFlags;
  int         n_errors = 0;
  int         n_checks = 0;
  // shared return line pulled up when no device drives it
  assign sdoLine = sdoOeN ? 1'b1 : sdoOut;
  fic_top uut (.mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .alarmOut(alarmOut),
    .alarmOeN(alarmOeN), .realFault(realFault), .faultFlags(faultFlags),
    .failSafe(failSafe), .injectState(injectState));
  fic_host host (.mclk(mclk), .sclk(sclk), .csN(csN), .sdi(sdi),
    .sdo(sdoLine));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [12:0] flagsOf(input logic [15:0] v);
    return {v[14], v[13], v[12], v[9], v[7], v[5], v[3], v[1],
            v[8], v[6], v[4], v[2], v[0]};
  endfunction
  function automatic logic [7:0] crcOf(input logic [15:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY[7:0] : 8'h00);
    return c;
  endfunction
  task automatic frame(input logic [23:0] f, input int n);
    host.xfer(f, n, rd);
    host.releaseBus();
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic chkFlags(input logic [15:0] v);
    chk(faultFlags, flagsOf(v));
    chk(failSafe, |flagsOf(v));
    chk(alarmOeN, ~|flagsOf(v));
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    realFault = '0;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(injectState, FIC_RESET);
    chkFlags(16'h0000);
    chk(sdoOeN, 16'h0001);
    chk(alarmOut, 16'h0000);
    frame({1'b1, FIC_ADDR, 16'h0000}, 24);
    chk(rd, FIC_RESET);
    for (int b = 0; b < 16; b++) begin
      w = 16'h0001 << b;
      frame({1'b0, FIC_ADDR, w}, 24);
      chk(injectState, w);
      chkFlags(w);
    end
    frame({1'b0, FIC_ADDR, 16'hFFFF}, 24);
    frame({1'b1, FIC_ADDR, 16'h0000}, 24);
    chk(rd, 16'hFFFF);
    chkFlags(16'hFFFF);
    frame({1'b0, 7'h2E, 16'h0000}, 24);
    chk(injectState, 16'hFFFF);
    host.xfer({1'b0, FIC_ADDR, 16'h0000}, 12, rd);
    chk(sdoOeN, 16'h0000);
    host.releaseBus();
    repeat (8) @(posedge mclk);
    #1 chk(injectState, 16'hFFFF);
    frame({1'b0, FIC_ADDR, 16'h0000}, 24);
    chkFlags(16'h0000);
    realFault.overtempWarning = 1'b1;
    repeat (4) @(posedge mclk);
    #1 chkFlags(16'h1000);
    realFault = '0;
    frame({1'b0, FIC_ADDR, 16'h00A5}, 24);
    frame({1'b1, FIC_ADDR, 16'h0000}, 32);
    chk(rd, {8'hA5, crcOf(16'h00A5)});
    frame({1'b0, FIC_ADDR, 16'h80A5}, 24);
    frame({1'b1, FIC_ADDR, 16'h0000}, 32);
    chk(rd, {8'hA5, ~crcOf(16'h80A5)});
    wrap_up();
  end
endmodule
`default_nettype wire
